/* File: bench/pmcm_chan_model.sv */
`timescale 1ns/1ps
module pmcm_chan_model
  import pmcm_pkg::*;
(
  input wire logic [3:0] i_faulted_off,
  input wire logic [3:0] i_pgood,
  output pmcm_chan_type [3:0] o_chan
);
  // fixed telemetry, channel number in low bits so a wrong page shows up
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      o_chan[c] = '{8'h10 | 8'(c), 8'h20 | 8'(c), 8'h30 | 8'(c), 16'h1000 | 16'(c), 16'h2000 | 16'(c),
        16'h0300 | 16'(c), 16'h4000 | 16'(c), 16'h0010 | 16'(c), 16'h5000 | 16'(c), i_faulted_off[c], i_pgood[c]};
    end
  end
endmodule

/* File: bench/test_power_monitor_command_map.sv */
`timescale 1ns/1ps
module test_power_monitor_command_map;
  import pmcm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pmcm_req_type req = '0;
  pmcm_chan_type [3:0] chan;
  logic [3:0] foff = 4'h0;
  logic [3:0] pg = 4'h0;
  logic wdog = 1'b1;
  logic ext0 = 1'b0;
  logic ext1 = 1'b0;
  logic fl0, fl1, oe0, oe1, pgood, act0, act1;
  logic [15:0] rdata;
  logic [15:0] tcomp [4];
  logic [7:0] resp0, resp1;
  int n_errors = 0;
  int checked = 0;
  always #20 clk = ~clk;
  // open-drain lines: low when anyone pulls
  assign fl0 = ~(ext0 | oe0);
  assign fl1 = ~(ext1 | oe1);
  pmcm_chan_model pmcm_chan_model_inst (.i_faulted_off(foff), .i_pgood(pg), .o_chan(chan));
  pmcm_top #(.REVISION_VALUE(8'h5A)) pmcm_top_inst (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_chan(chan),
    .i_st_input(8'h5C), .i_st_comm_mem(8'h3E), .i_vin(16'h6600), .i_temp_int(16'h7700), .i_watchdog_ok(wdog),
    .i_shared_fault_line0(fl0), .i_shared_fault_line1(fl1), .o_rdata(rdata), .o_temp_comp(tcomp),
    .o_shared_fault_line0_oe(oe0), .o_shared_fault_line1_oe(oe1), .o_power_good(pgood),
    .o_fault_action0(act0), .o_fault_action1(act1), .o_fault_resp0(resp0), .o_fault_resp1(resp1));
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, cmd, d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    @(posedge clk);
    req <= '{1'b0, 1'b1, cmd, 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk16(rdata, exp);
  endtask
  // one-cycle pulses are caught since every cycle is looked at
  task automatic wait_sig(input int k, input logic want);
    logic [4:0] s;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      s = {act0, act1, pgood, oe1, oe0};
      if (s[k] === want) begin
        chk16(16'(s[k]), 16'(want));
        return;
      end
    end
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    end_of_test();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(CMD_CHANNEL_CONFIG, 16'h0080);
    rd(CMD_GLOBAL_CONFIG, 16'h0F7B);
    rd(CMD_FAULT_LINE1_PROPAGATE, 16'h0000);
    rd(CMD_POWER_GOOD_MAP, 16'h0000);
    rd(CMD_FAULT_LINE1_RESPONSE, 16'h0000);
    rd(CMD_GLOBAL_PAGE_CHANNEL_MASK, 16'h000F);
    rd(CMD_PROTOCOL_REVISION, 16'h005A);
    rd(CMD_NVM_UNLOCK, 16'h0000);
    rd(CMD_NVM_DATA, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      automatic logic [15:0] v = 16'(c);
      wr(CMD_PAGE, v);
      rd(CMD_SELF_HEAT_THETA, 16'h8000);
      rd(CMD_STATUS_OUT_CURRENT, 16'h10 | v);
      rd(CMD_STATUS_EXT_TEMP, 16'h20 | v);
      rd(CMD_STATUS_VENDOR_SPECIFIC, 16'h30 | v);
      rd(CMD_STATUS_INPUT_SUPPLY, 16'h005C);
      rd(CMD_STATUS_COMM_MEMORY, 16'h003E);
      rd(CMD_MEAS_OUTPUT_CURRENT, 16'h2000 | v);
      rd(CMD_MEAS_OUTPUT_POWER, 16'h4000 | v);
      rd(CMD_MEAS_INPUT_VOLTAGE, 16'h6600);
      rd(CMD_MEAS_EXT_TEMP, 16'h0300 | v);
      chk16(tcomp[c], 16'h0310 + v + v);
      rd(CMD_SELF_HEAT_RISE, 16'h0010 | v);
      rd(CMD_ALT_CURRENT_READING, 16'h5000 | v);
      wr(CMD_MEAS_OUTPUT_VOLTAGE, 16'hDEAD);
      rd(CMD_MEAS_OUTPUT_VOLTAGE, 16'h1000 | v);
      wr(CMD_CHANNEL_CONFIG, 16'h0100 + v);
      wr(CMD_SCRATCHPAD_GLOBAL, 16'h0A00 + v);
    end
    wr(CMD_GLOBAL_PAGE_CHANNEL_MASK, 16'h0005);
    wr(CMD_PAGE, 16'h00FF);
    wr(CMD_SELF_HEAT_TAU_INVERSE, 16'h1234);
    for (int c = 0; c < 4; c++) begin
      wr(CMD_PAGE, 16'(c));
      rd(CMD_CHANNEL_CONFIG, 16'h0100 + 16'(c));
      rd(CMD_SCRATCHPAD_GLOBAL, 16'h0A03);
      rd(CMD_SELF_HEAT_TAU_INVERSE, c[0] ? 16'h8000 : 16'h1234);
    end
    for (int k = 0; k < 3; k++) begin
      wr(CMD_EXTRA_HOST_COMMAND + 8'(k), 16'hBE00 + 16'(k));
      rd(CMD_EXTRA_HOST_COMMAND + 8'(k), 16'hBE00 + 16'(k));
    end
    wr(CMD_NVM_UNLOCK, 16'h002B);
    rd(CMD_NVM_UNLOCK, 16'h0001);
    wr(CMD_NVM_ERASE, 16'h00C4);
    wr(CMD_NVM_DATA, 16'h1111);
    // relocked: the write, erase and read below must all bounce
    wr(CMD_NVM_UNLOCK, 16'h0000);
    wr(CMD_NVM_DATA, 16'h2222);
    wr(CMD_NVM_ERASE, 16'h00C4);
    rd(CMD_NVM_DATA, 16'h0000);
    wr(CMD_NVM_UNLOCK, 16'h002B);
    // walk the other 63 words so the pointer wraps back to the first one
    for (int i = 0; i < 63; i++) begin
      rd(CMD_NVM_DATA, 16'hFFFF);
    end
    rd(CMD_NVM_DATA, 16'h1111);
    wr(CMD_FAULT_LINE0_RESPONSE, 16'h0080);
    wr(CMD_FAULT_LINE1_RESPONSE, 16'h0080);
    @(negedge clk);
    chk16(16'(resp0), 16'h0080);
    chk16(16'(resp1), 16'h0080);
    @(posedge clk) ext0 <= 1'b1;
    wait_sig(4, 1'b1);
    @(posedge clk) ext0 <= 1'b0;
    @(posedge clk) ext1 <= 1'b1;
    wait_sig(3, 1'b1);
    @(posedge clk) ext1 <= 1'b0;
    wr(CMD_PAGE, 16'h0002);
    wr(CMD_FAULT_LINE0_PROPAGATE, 16'h0001);
    @(posedge clk) foff <= 4'b0100;
    wait_sig(0, 1'b1);
    chk16(16'(oe1), 16'h0000);
    wr(CMD_POWER_GOOD_MAP, 16'h0103);
    @(posedge clk) pg <= 4'b0001;
    wait_sig(2, 1'b0);
    @(posedge clk) pg <= 4'b0011;
    wait_sig(2, 1'b1);
    @(posedge clk) wdog <= 1'b0;
    wait_sig(2, 1'b0);
    // mid-run reset: config returns to defaults, pins to idle
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    @(negedge clk);
    chk16({13'h0000, pgood, oe0, act0}, 16'h0004);
    rd(CMD_FAULT_LINE0_PROPAGATE, 16'h0000);
    rd(CMD_NVM_UNLOCK, 16'h0000);
    end_of_test();
  end
endmodule

/* File: hdl/pmcm_nvm.sv */
`timescale 1ns/1ps
module pmcm_nvm
  import pmcm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_erase,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  typedef struct packed {
    logic [5:0] ptr;
    logic [15:0] rdata;
  } pmcm_nvm_state_type;
  pmcm_nvm_state_type st_r, st_nxt;
  logic [15:0] mem [NVM_WORDS];

  always_comb begin
    st_nxt = st_r;
    if (i_erase) begin
      st_nxt.ptr = '0;
    end else if (i_wr || i_rd) begin
      st_nxt.ptr = st_r.ptr + 6'h01;
    end
    if (i_rd) begin
      st_nxt.rdata = mem[st_r.ptr];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage cells have no reset, erase blanks them for bulk programming
  always_ff @(posedge i_ref_clk) begin
    for (int k = 0; k < NVM_WORDS; k++) begin
      if (i_erase) begin
        mem[k] <= 16'hFFFF;
      end else if (i_wr && st_r.ptr == k[5:0]) begin
        mem[k] <= i_wdata;
      end
    end
  end

  assign o_rdata = st_r.rdata;

  chk_nvm_ptr_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && !i_erase) |=> st_r.ptr == $past(st_r.ptr) + 6'h01) else $error("pointer did not advance");
  chk_nvm_erase_rewind: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_erase |=> st_r.ptr == 6'h00) else $error("erase did not rewind");
endmodule

/* File: hdl/pmcm_pkg.sv */
package pmcm_pkg;
  localparam int PMCM_CHANNELS = 4;
  localparam logic [7:0] PMCM_PAGE_GLOBAL = 8'hFF;
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_STATUS_OUT_CURRENT = 8'h7B;
  localparam logic [7:0] CMD_STATUS_INPUT_SUPPLY = 8'h7C;
  localparam logic [7:0] CMD_STATUS_EXT_TEMP = 8'h7D;
  localparam logic [7:0] CMD_STATUS_COMM_MEMORY = 8'h7E;
  localparam logic [7:0] CMD_STATUS_VENDOR_SPECIFIC = 8'h80;
  localparam logic [7:0] CMD_MEAS_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_MEAS_OUTPUT_VOLTAGE = 8'h8B;
  localparam logic [7:0] CMD_MEAS_OUTPUT_CURRENT = 8'h8C;
  localparam logic [7:0] CMD_MEAS_EXT_TEMP = 8'h8D;
  localparam logic [7:0] CMD_MEAS_INT_TEMP = 8'h8E;
  localparam logic [7:0] CMD_MEAS_OUTPUT_POWER = 8'h96;
  localparam logic [7:0] CMD_PROTOCOL_REVISION = 8'h98;
  localparam logic [7:0] CMD_TOOL_RESERVED_WORD0 = 8'hB0;
  localparam logic [7:0] CMD_TOOL_RESERVED_WORD1 = 8'hB1;
  localparam logic [7:0] CMD_OEM_RESERVED_WORD = 8'hB2;
  localparam logic [7:0] CMD_SCRATCHPAD_PAGED = 8'hB3;
  localparam logic [7:0] CMD_SCRATCHPAD_GLOBAL = 8'hB4;
  localparam logic [7:0] CMD_VENDOR_RESERVED_WORD1 = 8'hB5;
  localparam logic [7:0] CMD_VENDOR_INFO = 8'hB6;
  localparam logic [7:0] CMD_SELF_HEAT_RISE = 8'hB8;
  localparam logic [7:0] CMD_SELF_HEAT_TAU_INVERSE = 8'hB9;
  localparam logic [7:0] CMD_SELF_HEAT_THETA = 8'hBA;
  localparam logic [7:0] CMD_ALT_CURRENT_READING = 8'hBB;
  localparam logic [7:0] CMD_VENDOR_RESERVED_WORD2 = 8'hBC;
  localparam logic [7:0] CMD_NVM_UNLOCK = 8'hBD;
  localparam logic [7:0] CMD_NVM_ERASE = 8'hBE;
  localparam logic [7:0] CMD_NVM_DATA = 8'hBF;
  localparam logic [7:0] CMD_EXTRA_HOST_COMMAND = 8'hC8;
  localparam logic [7:0] CMD_EXTRA_HOST0_DATA = 8'hC9;
  localparam logic [7:0] CMD_EXTRA_HOST1_DATA = 8'hCA;
  localparam logic [7:0] CMD_CHANNEL_CONFIG = 8'hD0;
  localparam logic [7:0] CMD_GLOBAL_CONFIG = 8'hD1;
  localparam logic [7:0] CMD_FAULT_LINE0_PROPAGATE = 8'hD2;
  localparam logic [7:0] CMD_FAULT_LINE1_PROPAGATE = 8'hD3;
  localparam logic [7:0] CMD_POWER_GOOD_MAP = 8'hD4;
  localparam logic [7:0] CMD_FAULT_LINE0_RESPONSE = 8'hD5;
  localparam logic [7:0] CMD_FAULT_LINE1_RESPONSE = 8'hD6;
  localparam logic [7:0] CMD_GLOBAL_PAGE_CHANNEL_MASK = 8'hE4;
  localparam logic [15:0] RST_CHANNEL_CONFIG = 16'h0080;
  localparam logic [15:0] RST_GLOBAL_CONFIG = 16'h0F7B;
  localparam logic [15:0] RST_SELF_HEAT = 16'h8000;
  localparam logic [15:0] RST_WORD_ZERO = 16'h0000;
  localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RST_PAGE_MASK = 8'h0F;
  localparam logic [7:0] NVM_UNLOCK_KEY = 8'h2B;
  localparam logic [7:0] NVM_ERASE_KEY = 8'hC4;
  localparam int NVM_WORDS = 64;
  localparam int SELF_HEAT_SCALE = 4;
  localparam real ALT_CURRENT_LSB_MA = 2.5;
  localparam int PGOOD_WDOG_BIT = 8;
  localparam int FRESP_ACTIVE_BIT = 7;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } pmcm_req_type;

  typedef struct packed {
    logic [7:0] st_iout;
    logic [7:0] st_temp;
    logic [7:0] st_vendor;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp_ext;
    logic [15:0] pout;
    logic [15:0] self_rise;
    logic [15:0] alt_iout;
    logic faulted_off;
    logic pgood;
  } pmcm_chan_type;
endpackage

/* File: hdl/pmcm_top.sv */
// How it works
// - read-only status bytes, some shared, most per channel
// - voltage linear16, others linear11 read-only words
// - external diode temperature drives compensation
// - global byte reports protocol revision
// - alternate current reading, 2.5 mA lsb
// - per-channel self-heating rise word, read-only
// - per-channel writable inverse tau, default 0x8000
// - per-channel writable theta, default 0x8000
// - nvm erase and data refused until unlocked
// - erase write initialises nvm for programming
// - each data word access advances nvm location
// - extra hosts: shared command, two data words
// - channel config 0x0080, global config 0x0F7B
// - per-channel, per-line faulted-off propagation select
// - power good from watchdog/reset and channel map
// - external fault line pull triggers configured response
// - page 0xFF writes all masked channels
`timescale 1ns/1ps
module pmcm_top
  import pmcm_pkg::*;
#(
  parameter logic [15:0] VENDOR_INFO_VALUE = 16'h00A5, // arbitrary value
  parameter logic [7:0] REVISION_VALUE = 8'h22 // arbitrary value
)(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire pmcm_req_type i_req,
  input wire pmcm_chan_type [3:0] i_chan,
  input wire logic [7:0] i_st_input,
  input wire logic [7:0] i_st_comm_mem,
  input wire logic [15:0] i_vin,
  input wire logic [15:0] i_temp_int,
  input wire logic i_watchdog_ok,
  input wire logic i_shared_fault_line0,
  input wire logic i_shared_fault_line1,
  output logic [15:0] o_rdata,
  output logic [15:0] o_temp_comp [4],
  output logic o_shared_fault_line0_oe,
  output logic o_shared_fault_line1_oe,
  output logic o_power_good,
  output logic o_fault_action0,
  output logic o_fault_action1,
  output logic [7:0] o_fault_resp0,
  output logic [7:0] o_fault_resp1
);
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] page_mask;
    logic unlocked;
    logic [3:0][15:0] tau_inv;
    logic [3:0][15:0] theta;
    logic [3:0][15:0] ch_cfg;
    logic [3:0][15:0] scratch_p;
    logic [3:0][15:0] tool1;
    logic [3:0][15:0] rsv1;
    logic [3:0][15:0] rsv2;
    logic [3:0] prop0;
    logic [3:0] prop1;
    logic [15:0] glb_cfg;
    logic [15:0] scratch_g;
    logic [15:0] tool0;
    logic [15:0] oem;
    logic [15:0] xcmd;
    logic [15:0] xdata0;
    logic [15:0] xdata1;
    logic [15:0] pg_map;
    logic [7:0] fresp0;
    logic [7:0] fresp1;
    logic [15:0] rdata;
    logic fline0_q;
    logic fline1_q;
    logic act0;
    logic act1;
    logic pgood;
    logic oe0;
    logic oe1;
    logic nvm_rd_q;
  } pmcm_state_type;

  pmcm_state_type st_r, st_nxt;
  logic [15:0] nvm_rdata;
  logic nvm_erase, nvm_wr, nvm_rd;

  function automatic logic [3:0] chan_sel(input logic [7:0] page, input logic [7:0] mask);
    chan_sel = 4'h0;
    if (page == PMCM_PAGE_GLOBAL) begin
      chan_sel = mask[3:0];
    end else if (page < 8'h04) begin
      chan_sel[page[1:0]] = 1'b1;
    end
  endfunction

  function automatic logic [15:0] paged(input logic [3:0][15:0] r, input logic [7:0] page);
    paged = r[page[1:0]];
  endfunction

  logic [3:0] wsel;
  logic [1:0] ch;
  logic [3:0][15:0] v_st_iout, v_st_temp, v_st_vend, v_vout, v_iout, v_temp, v_pout, v_rise, v_alt;
  logic [3:0][15:0] v_prop0, v_prop1;
  logic [3:0] foff_v;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      v_st_iout[k] = {8'h00, i_chan[k].st_iout};
      v_st_temp[k] = {8'h00, i_chan[k].st_temp};
      v_st_vend[k] = {8'h00, i_chan[k].st_vendor};
      v_vout[k] = i_chan[k].vout;
      v_iout[k] = i_chan[k].iout;
      v_temp[k] = i_chan[k].temp_ext;
      v_pout[k] = i_chan[k].pout;
      v_rise[k] = i_chan[k].self_rise;
      v_alt[k] = i_chan[k].alt_iout;
      v_prop0[k] = {15'h0000, st_r.prop0[k]};
      v_prop1[k] = {15'h0000, st_r.prop1[k]};
      foff_v[k] = i_chan[k].faulted_off;
    end
  end

  assign wsel = chan_sel(st_r.page, st_r.page_mask);
  assign ch = st_r.page[1:0];
  assign nvm_erase = i_req.wr && i_req.cmd == CMD_NVM_ERASE && st_r.unlocked
    && i_req.wdata[7:0] == NVM_ERASE_KEY;
  assign nvm_wr = i_req.wr && i_req.cmd == CMD_NVM_DATA && st_r.unlocked;
  assign nvm_rd = i_req.rd && i_req.cmd == CMD_NVM_DATA && st_r.unlocked;

  always_comb begin
    st_nxt = st_r;
    if (i_req.wr) begin
      if (i_req.cmd == CMD_PAGE) begin
        st_nxt.page = i_req.wdata[7:0];
      end else if (i_req.cmd == CMD_GLOBAL_PAGE_CHANNEL_MASK) begin
        st_nxt.page_mask = i_req.wdata[7:0];
      end else if (i_req.cmd == CMD_NVM_UNLOCK) begin
        st_nxt.unlocked = i_req.wdata[7:0] == NVM_UNLOCK_KEY;
      end else if (i_req.cmd == CMD_GLOBAL_CONFIG) begin
        st_nxt.glb_cfg = i_req.wdata;
      end else if (i_req.cmd == CMD_SCRATCHPAD_GLOBAL) begin
        st_nxt.scratch_g = i_req.wdata;
      end else if (i_req.cmd == CMD_TOOL_RESERVED_WORD0) begin
        st_nxt.tool0 = i_req.wdata;
      end else if (i_req.cmd == CMD_OEM_RESERVED_WORD) begin
        st_nxt.oem = i_req.wdata;
      end else if (i_req.cmd == CMD_EXTRA_HOST_COMMAND) begin
        st_nxt.xcmd = i_req.wdata;
      end else if (i_req.cmd == CMD_EXTRA_HOST0_DATA) begin
        st_nxt.xdata0 = i_req.wdata;
      end else if (i_req.cmd == CMD_EXTRA_HOST1_DATA) begin
        st_nxt.xdata1 = i_req.wdata;
      end else if (i_req.cmd == CMD_POWER_GOOD_MAP) begin
        st_nxt.pg_map = i_req.wdata;
      end else if (i_req.cmd == CMD_FAULT_LINE0_RESPONSE) begin
        st_nxt.fresp0 = i_req.wdata[7:0];
      end else if (i_req.cmd == CMD_FAULT_LINE1_RESPONSE) begin
        st_nxt.fresp1 = i_req.wdata[7:0];
      end
      // paged writes land in every selected copy; read-only codes fall through untouched
      for (int k = 0; k < 4; k++) begin
        if (wsel[k]) begin
          if (i_req.cmd == CMD_SELF_HEAT_TAU_INVERSE) begin
            st_nxt.tau_inv[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_SELF_HEAT_THETA) begin
            st_nxt.theta[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_CHANNEL_CONFIG) begin
            st_nxt.ch_cfg[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_SCRATCHPAD_PAGED) begin
            st_nxt.scratch_p[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_TOOL_RESERVED_WORD1) begin
            st_nxt.tool1[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_VENDOR_RESERVED_WORD1) begin
            st_nxt.rsv1[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_VENDOR_RESERVED_WORD2) begin
            st_nxt.rsv2[k] = i_req.wdata;
          end else if (i_req.cmd == CMD_FAULT_LINE0_PROPAGATE) begin
            st_nxt.prop0[k] = i_req.wdata[0];
          end else if (i_req.cmd == CMD_FAULT_LINE1_PROPAGATE) begin
            st_nxt.prop1[k] = i_req.wdata[0];
          end
        end
      end
    end

    if (i_req.rd) begin
      if (i_req.cmd == CMD_STATUS_INPUT_SUPPLY) begin
        st_nxt.rdata = {8'h00, i_st_input};
      end else if (i_req.cmd == CMD_STATUS_COMM_MEMORY) begin
        st_nxt.rdata = {8'h00, i_st_comm_mem};
      end else if (i_req.cmd == CMD_STATUS_OUT_CURRENT) begin
        st_nxt.rdata = paged(v_st_iout, st_r.page);
      end else if (i_req.cmd == CMD_STATUS_EXT_TEMP) begin
        st_nxt.rdata = paged(v_st_temp, st_r.page);
      end else if (i_req.cmd == CMD_STATUS_VENDOR_SPECIFIC) begin
        st_nxt.rdata = paged(v_st_vend, st_r.page);
      end else if (i_req.cmd == CMD_MEAS_INPUT_VOLTAGE) begin
        st_nxt.rdata = i_vin;
      end else if (i_req.cmd == CMD_MEAS_OUTPUT_VOLTAGE) begin
        st_nxt.rdata = paged(v_vout, st_r.page);
      end else if (i_req.cmd == CMD_MEAS_OUTPUT_CURRENT) begin
        st_nxt.rdata = paged(v_iout, st_r.page);
      end else if (i_req.cmd == CMD_MEAS_EXT_TEMP) begin
        st_nxt.rdata = paged(v_temp, st_r.page);
      end else if (i_req.cmd == CMD_MEAS_INT_TEMP) begin
        st_nxt.rdata = i_temp_int;
      end else if (i_req.cmd == CMD_MEAS_OUTPUT_POWER) begin
        st_nxt.rdata = paged(v_pout, st_r.page);
      end else if (i_req.cmd == CMD_PROTOCOL_REVISION) begin
        st_nxt.rdata = {8'h00, REVISION_VALUE};
      end else if (i_req.cmd == CMD_TOOL_RESERVED_WORD0) begin
        st_nxt.rdata = st_r.tool0;
      end else if (i_req.cmd == CMD_TOOL_RESERVED_WORD1) begin
        st_nxt.rdata = paged(st_r.tool1, st_r.page);
      end else if (i_req.cmd == CMD_OEM_RESERVED_WORD) begin
        st_nxt.rdata = st_r.oem;
      end else if (i_req.cmd == CMD_SCRATCHPAD_PAGED) begin
        st_nxt.rdata = paged(st_r.scratch_p, st_r.page);
      end else if (i_req.cmd == CMD_SCRATCHPAD_GLOBAL) begin
        st_nxt.rdata = st_r.scratch_g;
      end else if (i_req.cmd == CMD_VENDOR_RESERVED_WORD1) begin
        st_nxt.rdata = paged(st_r.rsv1, st_r.page);
      end else if (i_req.cmd == CMD_VENDOR_INFO) begin
        st_nxt.rdata = VENDOR_INFO_VALUE;
      end else if (i_req.cmd == CMD_SELF_HEAT_RISE) begin
        st_nxt.rdata = paged(v_rise, st_r.page);
      end else if (i_req.cmd == CMD_SELF_HEAT_TAU_INVERSE) begin
        st_nxt.rdata = paged(st_r.tau_inv, st_r.page);
      end else if (i_req.cmd == CMD_SELF_HEAT_THETA) begin
        st_nxt.rdata = paged(st_r.theta, st_r.page);
      end else if (i_req.cmd == CMD_ALT_CURRENT_READING) begin
        st_nxt.rdata = paged(v_alt, st_r.page);
      end else if (i_req.cmd == CMD_VENDOR_RESERVED_WORD2) begin
        st_nxt.rdata = paged(st_r.rsv2, st_r.page);
      end else if (i_req.cmd == CMD_NVM_UNLOCK) begin
        st_nxt.rdata = {15'h0000, st_r.unlocked};
      end else if (i_req.cmd == CMD_EXTRA_HOST_COMMAND) begin
        st_nxt.rdata = st_r.xcmd;
      end else if (i_req.cmd == CMD_EXTRA_HOST0_DATA) begin
        st_nxt.rdata = st_r.xdata0;
      end else if (i_req.cmd == CMD_EXTRA_HOST1_DATA) begin
        st_nxt.rdata = st_r.xdata1;
      end else if (i_req.cmd == CMD_CHANNEL_CONFIG) begin
        st_nxt.rdata = paged(st_r.ch_cfg, st_r.page);
      end else if (i_req.cmd == CMD_GLOBAL_CONFIG) begin
        st_nxt.rdata = st_r.glb_cfg;
      end else if (i_req.cmd == CMD_FAULT_LINE0_PROPAGATE) begin
        st_nxt.rdata = paged(v_prop0, st_r.page);
      end else if (i_req.cmd == CMD_FAULT_LINE1_PROPAGATE) begin
        st_nxt.rdata = paged(v_prop1, st_r.page);
      end else if (i_req.cmd == CMD_POWER_GOOD_MAP) begin
        st_nxt.rdata = st_r.pg_map;
      end else if (i_req.cmd == CMD_FAULT_LINE0_RESPONSE) begin
        st_nxt.rdata = {8'h00, st_r.fresp0};
      end else if (i_req.cmd == CMD_FAULT_LINE1_RESPONSE) begin
        st_nxt.rdata = {8'h00, st_r.fresp1};
      end else if (i_req.cmd == CMD_PAGE) begin
        st_nxt.rdata = {8'h00, st_r.page};
      end else if (i_req.cmd == CMD_GLOBAL_PAGE_CHANNEL_MASK) begin
        st_nxt.rdata = {8'h00, st_r.page_mask};
      end else begin
        st_nxt.rdata = 16'h0000;
      end
    end

    // fault lines are open drain: pull low when any propagating channel is faulted off
    st_nxt.oe0 = 1'b0;
    st_nxt.oe1 = 1'b0;
    st_nxt.pgood = st_r.pg_map[PGOOD_WDOG_BIT] ? i_watchdog_ok : 1'b1;
    for (int k = 0; k < 4; k++) begin
      st_nxt.oe0 = st_nxt.oe0 | (st_r.prop0[k] & i_chan[k].faulted_off);
      st_nxt.oe1 = st_nxt.oe1 | (st_r.prop1[k] & i_chan[k].faulted_off);
      if (st_r.pg_map[k]) begin
        st_nxt.pgood = st_nxt.pgood & i_chan[k].pgood;
      end
    end
    // our own pull-down must not retrigger our response
    st_nxt.fline0_q = i_shared_fault_line0 | st_r.oe0;
    st_nxt.fline1_q = i_shared_fault_line1 | st_r.oe1;
    st_nxt.act0 = st_r.fline0_q & ~st_nxt.fline0_q & st_r.fresp0[FRESP_ACTIVE_BIT];
    st_nxt.act1 = st_r.fline1_q & ~st_nxt.fline1_q & st_r.fresp1[FRESP_ACTIVE_BIT];
    st_nxt.nvm_rd_q = nvm_rd;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.page_mask <= RST_PAGE_MASK;
      st_r.tau_inv <= {4{RST_SELF_HEAT}};
      st_r.theta <= {4{RST_SELF_HEAT}};
      st_r.ch_cfg <= {4{RST_CHANNEL_CONFIG}};
      st_r.glb_cfg <= RST_GLOBAL_CONFIG;
      st_r.fline0_q <= 1'b1;
      st_r.fline1_q <= 1'b1;
      st_r.pgood <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  pmcm_nvm u_nvm (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_erase(nvm_erase),
    .i_wr(nvm_wr),
    .i_rd(nvm_rd),
    .i_wdata(i_req.wdata),
    .o_rdata(nvm_rdata)
  );

  assign o_rdata = st_r.nvm_rd_q ? nvm_rdata : st_r.rdata;
  // compensation sees the external diode, never the junction sensor
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_temp_comp[k] = 16'(i_chan[k].temp_ext + i_chan[k].self_rise);
    end
  end
  assign o_shared_fault_line0_oe = st_r.oe0;
  assign o_shared_fault_line1_oe = st_r.oe1;
  assign o_power_good = st_r.pgood;
  assign o_fault_action0 = st_r.act0;
  assign o_fault_action1 = st_r.act1;
  assign o_fault_resp0 = st_r.fresp0;
  assign o_fault_resp1 = st_r.fresp1;

  chk_locked_no_erase: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !st_r.unlocked |-> !nvm_erase && !nvm_wr) else $error("nvm touched while locked");
  chk_ro_write_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.cmd == CMD_MEAS_OUTPUT_VOLTAGE)
    |=> st_r.rdata == $past(st_r.rdata) && st_r.ch_cfg == $past(st_r.ch_cfg) && st_r.tau_inv == $past(st_r.tau_inv))
    else $error("ro write");
  chk_global_page_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.cmd == CMD_SELF_HEAT_TAU_INVERSE && st_r.page == PMCM_PAGE_GLOBAL && st_r.page_mask[0])
    |=> st_r.tau_inv[0] == $past(i_req.wdata)) else $error("global page write missed");
  chk_paged_read_sel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.cmd == CMD_MEAS_OUTPUT_VOLTAGE) |=> st_r.rdata == $past(i_chan[ch].vout)) else $error("vout");
  chk_revision_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.cmd == CMD_PROTOCOL_REVISION) |=> st_r.rdata[7:0] == REVISION_VALUE) else $error("rev");
  chk_fault_prop_line: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (|(st_r.prop0 & foff_v)) |=> o_shared_fault_line0_oe) else $error("no pull");
  chk_pgood_watchdog: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st_r.pg_map[PGOOD_WDOG_BIT] && !i_watchdog_ok) |=> !o_power_good) else $error("pgood");
  chk_fault_response: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_fault_action0 |-> $past(st_r.fresp0[FRESP_ACTIVE_BIT])) else $error("action");
endmodule
